/* File: core/sdl_pkg.sv */
// Constants and types shared by the serial load and select block.
package sdl_pkg;
  // Serial word layout.
  localparam int          WORD_BITS      = 16;
  localparam logic [4:0]  LAST_BIT       = 5'h0F;
  localparam int          POS_SYNC       = 12;
  localparam int          POS_ORIGIN     = 11;
  localparam int          POS_SLEEP      = 13;
  localparam int          POS_RESET      = 12;
  localparam int          POS_CLEAR      = 11;
  localparam int          POS_FBIT       = 11;
  localparam int          POS_PBIT_HI    = 10;
  localparam int          POS_PBIT_LO    = 9;
  localparam logic [2:0]  TOP_SYNC_WORD  = 3'h6;
  localparam logic [1:0]  TOP_CTRL_WORD  = 2'h3;
  // Default command codes; the values are a free choice and are module parameters.
  localparam logic [3:0]  DEF_PH_DEFER   = 4'h0;
  localparam logic [3:0]  DEF_PH_DIRECT  = 4'h1;
  localparam logic [3:0]  DEF_FR_DEFER   = 4'h2;
  localparam logic [3:0]  DEF_FR_DIRECT  = 4'h3;
  localparam logic [3:0]  DEF_SEL_BITS   = 4'h8;
  // Datapath widths and latency.
  localparam int          ACC_BITS       = 32;
  localparam int          PH_BITS        = 12;
  localparam int          OUT_DLY        = 2;
  // Register bus map (byte addresses) and reset values.
  localparam logic [11:0] ADDR_STATUS    = 12'h000;
  localparam logic [11:0] ADDR_INJECT    = 12'h004;
  localparam logic [11:0] ADDR_PHASE     = 12'h008;
  localparam logic        RST_RESET_BIT  = 1'b1;
  localparam logic        RST_OTHER_BIT  = 1'b0;

  // One 16-bit serial word split into its fields.
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [7:0] data;
  } sdl_word_t;
endpackage : sdl_pkg

/* File: core/sdl_core.sv */
// Serial load path, register selection and phase accumulator of the oscillator.
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module sdl_core #(
  parameter logic [3:0] PH_DEFER  = sdl_pkg::DEF_PH_DEFER,
  parameter logic [3:0] PH_DIRECT = sdl_pkg::DEF_PH_DIRECT,
  parameter logic [3:0] FR_DEFER  = sdl_pkg::DEF_FR_DEFER,
  parameter logic [3:0] FR_DIRECT = sdl_pkg::DEF_FR_DIRECT,
  parameter logic [3:0] SEL_BITS  = sdl_pkg::DEF_SEL_BITS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_clk,
  input  wire logic        serial_data_in,
  input  wire logic        frame_strobe_n,
  input  wire logic        freq_word_choice,
  input  wire logic        phase_choice_bit0,
  input  wire logic        phase_choice_bit1,
  output logic      [11:0] phase_out,
  output logic             sleep_out
);

  logic              sclk_q;
  logic [4:0]        bit_cnt;
  logic [14:0]       shift_q;
  logic              ser_done;
  sdl_pkg::sdl_word_t ser_word;
  logic              inj_pend;
  sdl_pkg::sdl_word_t inj_word;
  logic              word_v;
  sdl_pkg::sdl_word_t word_in;
  logic              p1_v;
  logic              p2_v;
  sdl_pkg::sdl_word_t p1_w;
  sdl_pkg::sdl_word_t p2_w;
  logic              apply_v;
  sdl_pkg::sdl_word_t aw;
  logic [15:0]       staging;
  logic [15:0]       next_staging;
  logic [15:0]       data_reg;
  logic              dest_pend;
  logic [3:0]        dest_cmd;
  logic [3:0]        dest_addr;
  logic [31:0]       freq_word_a;
  logic [31:0]       freq_word_b;
  logic [11:0]       phase_offset_value [4];
  logic              sync_en;
  logic              choice_origin;
  logic              sleep_bit;
  logic              reset_bit;
  logic              clear_control;
  logic              fbit;
  logic [1:0]        pbits;
  logic [2:0]        pin_q;
  logic [2:0]        pin_s1;
  logic [2:0]        pin_s2;
  logic [2:0]        pin_used;
  logic [2:0]        sel_q;
  logic [31:0]       freq_word_value;
  logic [31:0]       acc;
  logic [11:0]       phase_sum;
  logic [11:0]       dly [sdl_pkg::OUT_DLY];
  logic              fall;
  logic              acc_wr;

  // A falling serial clock is found by comparing two samples, so any idle level works.
  assign fall = sclk_q & ~serial_clk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= serial_clk;
    end
  end

  // Shift in one bit per fall while framed, most significant first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt  <= 5'h00;
      shift_q  <= 15'h0000;
      ser_done <= 1'b0;
      ser_word <= '0;
    end else begin
      ser_done <= 1'b0;
      if (frame_strobe_n) begin
        bit_cnt <= 5'h00;
      end else if (fall) begin
        shift_q <= {shift_q[13:0], serial_data_in};
        if (bit_cnt == sdl_pkg::LAST_BIT) begin
          bit_cnt  <= 5'h00;
          ser_done <= 1'b1;
          ser_word <= {shift_q, serial_data_in};
        end else begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
    end
  end

  // Bus-injected words wait while a serial word is in the same cycle.
  assign word_v  = ser_done | inj_pend;
  assign word_in = ser_done ? ser_word : inj_word;

  // Two-stage transfer pipeline, used only while the synchronizer is on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_v <= 1'b0;
      p2_v <= 1'b0;
      p1_w <= '0;
      p2_w <= '0;
    end else begin
      p1_v <= word_v & sync_en;
      p1_w <= word_in;
      p2_v <= p1_v;
      p2_w <= p1_w;
    end
  end

  assign apply_v = sync_en ? p2_v : (word_v & ~p1_v & ~p2_v);
  assign aw      = sync_en ? p2_w : word_in;

  // Merge the new byte into the addressed staging half.
  always_comb begin
    next_staging = staging;
    if (aw.addr[0]) begin
      next_staging[15:8] = aw.data;
    end else begin
      next_staging[7:0] = aw.data;
    end
  end

  // Staging and data register; a deferred write touches staging only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      staging   <= 16'h0000;
      data_reg  <= 16'h0000;
      dest_pend <= 1'b0;
      dest_cmd  <= 4'h0;
      dest_addr <= 4'h0;
    end else begin
      dest_pend <= 1'b0;
      if (apply_v && (aw.cmd == PH_DEFER || aw.cmd == FR_DEFER)) begin
        staging <= next_staging;
      end else if (apply_v && (aw.cmd == PH_DIRECT || aw.cmd == FR_DIRECT)) begin
        staging   <= next_staging;
        data_reg  <= next_staging;
        dest_pend <= 1'b1;
        dest_cmd  <= aw.cmd;
        dest_addr <= aw.addr;
      end
    end
  end

  // Target registers load one edge after the data register; reset leaves them alone.
  always_ff @(posedge pclk) begin
    if (dest_pend && dest_cmd == FR_DIRECT) begin
      if (!dest_addr[2] && dest_addr[1]) begin
        freq_word_a[31:16] <= data_reg;
      end else if (!dest_addr[2]) begin
        freq_word_a[15:0] <= data_reg;
      end else if (dest_addr[1]) begin
        freq_word_b[31:16] <= data_reg;
      end else begin
        freq_word_b[15:0] <= data_reg;
      end
    end else if (dest_pend) begin
      phase_offset_value[dest_addr[2:1]] <= data_reg[11:0];
    end
  end

  // Control words; clear holds synchronizer and origin at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_en       <= sdl_pkg::RST_OTHER_BIT;
      choice_origin <= sdl_pkg::RST_OTHER_BIT;
      sleep_bit     <= sdl_pkg::RST_OTHER_BIT;
      reset_bit     <= sdl_pkg::RST_RESET_BIT;
      clear_control <= sdl_pkg::RST_OTHER_BIT;
      fbit          <= 1'b0;
      pbits         <= 2'h0;
    end else begin
      if (clear_control) begin
        sync_en       <= 1'b0;
        choice_origin <= 1'b0;
      end else if (apply_v && aw[15:13] == sdl_pkg::TOP_SYNC_WORD) begin
        sync_en       <= aw[sdl_pkg::POS_SYNC];
        choice_origin <= aw[sdl_pkg::POS_ORIGIN];
      end
      if (apply_v && aw[15:14] == sdl_pkg::TOP_CTRL_WORD
          && aw[15:13] != sdl_pkg::TOP_SYNC_WORD) begin
        sleep_bit     <= aw[sdl_pkg::POS_SLEEP];
        reset_bit     <= aw[sdl_pkg::POS_RESET];
        clear_control <= aw[sdl_pkg::POS_CLEAR];
      end
      if (apply_v && aw.cmd == SEL_BITS) begin
        fbit  <= aw[sdl_pkg::POS_FBIT];
        pbits <= aw[sdl_pkg::POS_PBIT_HI:sdl_pkg::POS_PBIT_LO];
      end
    end
  end

  // Pins are taken once, then twice more when synchronized, so only settled values count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q  <= 3'h0;
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      sel_q  <= 3'h0;
    end else begin
      pin_q  <= {phase_choice_bit1, phase_choice_bit0, freq_word_choice};
      pin_s1 <= pin_q;
      pin_s2 <= pin_s1;
      sel_q  <= choice_origin ? {pbits, fbit} : pin_used;
    end
  end

  assign pin_used        = sync_en ? pin_s2 : pin_q;
  assign freq_word_value = sel_q[0] ? freq_word_b : freq_word_a;

  // Accumulator wraps naturally at its width.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 32'h00000000;
    end else if (reset_bit) begin
      acc <= 32'h00000000;
    end else begin
      acc <= acc + freq_word_value;
    end
  end

  // Truncate then offset, and delay so every path lands on the documented latency.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_sum <= 12'h000;
      phase_out <= 12'h000;
      for (int i = 0; i < sdl_pkg::OUT_DLY; i++) begin
        dly[i] <= 12'h000;
      end
    end else begin
      phase_sum <= acc[31:20] + phase_offset_value[sel_q[2:1]];
      dly[0]    <= phase_sum;
      for (int i = 1; i < sdl_pkg::OUT_DLY; i++) begin
        dly[i] <= dly[i-1];
      end
      phase_out <= dly[sdl_pkg::OUT_DLY-1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_out <= 1'b0;
    end else begin
      sleep_out <= sleep_bit;
    end
  end

  // APB slave: one wait state; an inject write stalls while the previous one waits.
  assign acc_wr = psel & penable & pready & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready
          && !(pwrite && paddr == sdl_pkg::ADDR_INJECT && inj_pend)) begin
        pready <= 1'b1;
        prdata <= 32'h00000000;
        unique case (paddr)
          sdl_pkg::ADDR_STATUS: prdata <= {24'h000000, sel_q, clear_control,
                                           sleep_bit, reset_bit, choice_origin, sync_en};
          sdl_pkg::ADDR_INJECT: prdata <= {31'h00000000, inj_pend};
          sdl_pkg::ADDR_PHASE:  prdata <= {20'h00000, phase_out};
          default:              pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Injected word waits until no serial word holds the decode path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inj_pend <= 1'b0;
      inj_word <= '0;
    end else if (acc_wr && paddr == sdl_pkg::ADDR_INJECT) begin
      inj_pend <= 1'b1;
      inj_word <= pwdata[15:0];
    end else if (!ser_done) begin
      inj_pend <= 1'b0;
    end
  end

  // Checks.
  strobe_high_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
    frame_strobe_n |=> bit_cnt == 5'h00) else $error("bit count not cleared by strobe");
  word_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fall && !frame_strobe_n && bit_cnt == sdl_pkg::LAST_BIT)
      |=> ser_done && ser_word[0] == $past(serial_data_in))
    else $error("sixteenth bit did not complete a word");
  direct_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ser_done && !sync_en && !p1_v && !p2_v) |-> apply_v) else $error("unsynced word not applied");
  sync_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ser_done && sync_en && $stable(sync_en)) |=> !apply_v ##1 (apply_v || !sync_en))
    else $error("synced word not applied two stages later");
  clear_forces_a: assert property (@(posedge pclk) disable iff (!presetn)
    clear_control |=> !sync_en && !choice_origin) else $error("clear did not force zero");
  reset_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
    reset_bit [*2] |-> acc == 32'h00000000) else $error("accumulator not held at zero");
  acc_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    !reset_bit |=> acc == $past(acc) + $past(freq_word_value))
    else $error("accumulator step wrong");
  defer_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apply_v && aw.cmd == FR_DEFER) |=> $stable(data_reg) && !dest_pend)
    else $error("deferred write changed data register");
  direct_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apply_v && aw.cmd == FR_DIRECT) |=> dest_pend && data_reg == staging)
    else $error("direct write did not copy staging");
  out_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    !reset_bit |-> ##3 phase_out == $past(phase_sum, 3)) else $error("output delay wrong");
  origin_mux_a: assert property (@(posedge pclk) disable iff (!presetn)
    (choice_origin && $stable(choice_origin)) |=> sel_q == $past({pbits, fbit}))
    else $error("bits not used as selection source");

endmodule : sdl_core

/* File: dv/sdl_host.sv */
// Behavioural host serial port that frames one 16-bit word per call.
`timescale 1ns/10ps
module sdl_host (
  input  wire logic pclk,
  output logic      serial_clk,
  output logic      serial_data_in,
  output logic      frame_strobe_n
);
  // Idle state before the first frame: strobe high, clock parked low.
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    frame_strobe_n = 1'b1;
  end

  // Each bit is set with the clock high and taken on the fall two cycles later.
  // The clock spends two master cycles high and three low so every fall is seen.
  task automatic send(input logic [15:0] w, input logic park);
    frame_strobe_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge pclk);
      serial_clk <= 1'b1;
      serial_data_in <= w[i];
      repeat (2) @(posedge pclk);
      serial_clk <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    // The released data line shows the inverse so a stale bit is never trusted.
    frame_strobe_n <= 1'b1;
    serial_clk <= park;
    serial_data_in <= ~w[0];
    @(posedge pclk);
  endtask : send
endmodule : sdl_host

/* File: dv/tb.sv */
// Self-checking testbench for the serial load and select block.
`timescale 1ns/10ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_out;
  logic [11:0] paddr, phase_out, a;
  logic [31:0] pwdata, prdata, q;
  logic        e, park, fpin, p0, p1;
  logic        serial_clk, serial_data_in, frame_strobe_n;
  int          err_total, total_checks, cycles;
  // Each row holds the phase pins and the offset expected on phase_out.
  localparam logic [13:0] ROWS [4] = '{14'h0123, 14'h1456, 14'h2789, 14'h3ABC};

  sdl_core DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .frame_strobe_n(frame_strobe_n),
    .freq_word_choice(fpin), .phase_choice_bit0(p0), .phase_choice_bit1(p1),
    .phase_out(phase_out), .sleep_out(sleep_out));
  sdl_host host (.pclk(pclk), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .frame_strobe_n(frame_strobe_n));

  // Clock generator, 40 ns period.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Hang guard: the whole run needs well under the ceiling.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks = total_checks + 1;
    if (g !== x) begin
      err_total = err_total + 1;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // One APB transfer; the request is held until pready is sampled high.
  // The wait has no limit of its own; the hang guard ends a stuck transfer.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so a following call never reassigns psel in this time step.
    @(posedge pclk);
    chk("slave error", {31'h0, ad != sdl_pkg::ADDR_STATUS && ad != sdl_pkg::ADDR_INJECT
      && ad != sdl_pkg::ADDR_PHASE}, {31'h0, e});
  endtask : apb

  // Serial word; the idle clock level alternates between frames.
  task automatic wr(input logic [15:0] w);
    park = ~park;
    host.send(w, park);
  endtask : wr

  task automatic ctl(input logic rst, input logic clr);
    wr({3'h7, rst, clr, 11'h000});
  endtask : ctl

  // Deferred upper byte first, then direct lower byte, top nibble zero.
  task automatic ph(input logic [1:0] i, input logic [11:0] v);
    wr({sdl_pkg::DEF_PH_DEFER, 1'b0, i, 1'b1, 4'h0, v[11:8]});
    wr({sdl_pkg::DEF_PH_DIRECT, 1'b0, i, 1'b0, v[7:0]});
  endtask : ph

  // A frequency word is two halves, each loaded with two byte writes.
  task automatic fr(input logic b, input logic [31:0] v);
    wr({sdl_pkg::DEF_FR_DEFER, 1'b0, b, 2'h3, v[31:24]});
    wr({sdl_pkg::DEF_FR_DIRECT, 1'b0, b, 2'h2, v[23:16]});
    wr({sdl_pkg::DEF_FR_DEFER, 1'b0, b, 2'h1, v[15:8]});
    wr({sdl_pkg::DEF_FR_DIRECT, 1'b0, b, 2'h0, v[7:0]});
  endtask : fr

  // Pins are driven at edge 0; an output that moves at edge n is first read
  // here one edge later, so want is the latency plus one.
  task automatic lat(input logic [1:0] p, input int want);
    int n;
    n = 0;
    a = phase_out;
    {p1, p0} <= p;
    do begin
      @(posedge pclk);
      n++;
    end while (phase_out === a && n < 30);
    chk("pin latency", want, n);
  endtask : lat

  task automatic wait_chk(input string n, input logic [11:0] x);
    repeat (12) @(posedge pclk);
    chk(n, {20'h0, x}, {20'h0, phase_out});
  endtask : wait_chk

  // Phase step between two consecutive samples.
  task automatic step_chk(input logic [11:0] x);
    a = phase_out;
    @(posedge pclk);
    chk("phase step", {20'h0, x}, {20'h0, phase_out - a});
  endtask : step_chk

  initial begin
    {presetn, psel, penable, pwrite, fpin, p0, p1, park} = '0;
    paddr = '0;
    pwdata = '0;
    {err_total, total_checks, cycles} = '0;
    repeat (5) @(posedge pclk);
    chk("reset phase", 32'h0, {20'h0, phase_out});
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, sdl_pkg::ADDR_STATUS, 32'h0);
    chk("status reset", 32'h4, q);
    ctl(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) ph(ROWS[i][13:12], ROWS[i][11:0]);
    fr(1'b0, 32'h0010_0000);
    fr(1'b1, 32'h0030_0000);
    // Table: pins pick the phase register while the accumulator is held at 0.
    for (int i = 0; i < 4; i++) begin
      {p1, p0} <= ROWS[i][13:12];
      wait_chk("row phase", ROWS[i][11:0]);
    end
    lat(2'h0, 7);
    {p1, p0} <= 2'h1;
    wr({sdl_pkg::DEF_PH_DEFER, 4'h3, 8'h00});
    wait_chk("deferred", 12'h456);
    wr({sdl_pkg::DEF_PH_DIRECT, 4'h2, 8'h55});
    wait_chk("direct", 12'h055);
    wr({sdl_pkg::DEF_PH_DIRECT, 4'h2, 8'h66});
    wait_chk("direct only", 12'h066);
    wr({3'h6, 1'b0, 1'b1, 11'h000});
    wr({sdl_pkg::DEF_SEL_BITS, 1'b0, 2'h2, 9'h000});
    wait_chk("bits select", 12'h789);
    apb(1'b0, sdl_pkg::ADDR_STATUS, 32'h0);
    chk("status bits", 32'h8E, q);
    ctl(1'b1, 1'b1);
    apb(1'b0, sdl_pkg::ADDR_STATUS, 32'h0);
    chk("status clear", 32'h1C, {27'h0, q[4:0]});
    wait_chk("clear pins", 12'h066);
    ctl(1'b1, 1'b0);
    wr({3'h6, 1'b1, 1'b0, 11'h000});
    lat(2'h3, 9);
    wr({3'h6, 1'b0, 1'b0, 11'h000});
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    apb(1'b1, sdl_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, sdl_pkg::ADDR_STATUS, 32'h0);
    chk("status ro", 32'h0C, {27'h0, q[4:0]});
    {p1, p0} <= 2'h0;
    apb(1'b1, sdl_pkg::ADDR_INJECT, 32'h0000_E000);
    repeat (20) @(posedge pclk);
    step_chk(12'h001);
    fpin <= 1'b1;
    repeat (12) @(posedge pclk);
    step_chk(12'h003);
    chk("sleep", 32'h1, {31'h0, sleep_out});
    ctl(1'b1, 1'b0);
    wait_chk("reset hold", 12'h123);
    finish_test();
  end
endmodule : tb
